// ---- hdl/ipr_regs.sv ----
// AXI4-Lite bank of interrupt priority registers with a winner status word
//
// Notes on behaviour
// - Each source has a 3-bit field and code 111 is level 7, the highest user level.
// - Code 001 is level 1 and codes rise in step up to level 7.
// - Code 000 disables the source so it never wins arbitration.
// - Every field resets to level 4, top bit set and lower bits clear.
// - Bits that hold no field read as zero and ignore writes.
// - First register: timer 2 at 14-12, compare 2 at 10-8, capture 2 at 6-4.
// - Second register: serial rx 14-12, sync serial event 10-8, error 6-4, timer 3 2-0.
// - Third register: converter done 6-4, serial tx 2-0, bits 15-7 empty.
// - Fourth register: pin change 14-12, comparator 10-8, two-wire master 6-4, slave 2-0.
// - Motor PWM sits at bits 6-4 with the other bits empty.
// - Last register: fault A at 14-12, calendar at 10-8.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ipr_regs import ipr_pkg::*; #(
  parameter int NSRC = IPR_NUM_SRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [IPR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [IPR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0] irq_pending,
  output logic [3*NSRC-1:0] src_level,
  output logic irq_valid,
  output logic [4:0] irq_src,
  output logic [2:0] irq_level
);
  typedef struct packed {
    logic [NSRC-1:0][2:0] prio;
    logic aw_held;
    logic [IPR_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipr_state_t;
  ipr_state_t state;
  ipr_state_t next_state;
  logic win_valid;
  logic [4:0] win_src;
  logic [2:0] win_level;

  // Map a byte address to a register index; invalid index means unmapped
  function automatic logic [4:0] reg_index(input logic [IPR_ADDR_W-1:0] addr);
    case (addr)
      IPR_OFF_TIMER2_OC2_IC2: reg_index = 5'h00;
      IPR_OFF_UART_RX_SPI_TIMER3: reg_index = 5'h01;
      IPR_OFF_ADC_UART_TX: reg_index = 5'h02;
      IPR_OFF_CHANGE_CMP_I2C: reg_index = 5'h03;
      IPR_OFF_EXT_INT1: reg_index = 5'h04;
      IPR_OFF_EXT_INT2: reg_index = 5'h05;
      IPR_OFF_CAPTURE3: reg_index = 5'h06;
      IPR_OFF_MOTOR_PWM: reg_index = 5'h07;
      IPR_OFF_FAULT_A_CALENDAR: reg_index = 5'h08;
      IPR_OFF_WINNER: reg_index = 5'h09;
      default: reg_index = 5'h1F;
    endcase
  endfunction : reg_index

  // Assemble a register word; only field bits can be nonzero
  function automatic logic [31:0] reg_word(input logic [NSRC-1:0][2:0] prio,
                                           input logic [4:0] idx);
    logic [31:0] word;
    word = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (5'(IPR_SRC_REG[i]) == idx) begin
        word[IPR_SRC_LSB[i] +: 3] = prio[i];
      end
    end
    reg_word = word;
  endfunction : reg_word

  logic [4:0] widx;
  logic [4:0] ridx;
  logic do_write;
  logic do_read;
  assign widx = reg_index(state.aw_addr);
  assign ridx = reg_index(s_axi_araddr);
  assign do_write = state.aw_held && state.w_held && !state.bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  // Bus handshake, field update on write, read capture
  always_comb begin
    next_state = state;
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = (widx < 5'(IPR_NUM_REGS)) ? IPR_RESP_OKAY :
                         (widx == 5'h09) ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
      // Field write: unimplemented bits are simply not stored
      for (int i = 0; i < NSRC; i++) begin
        if (5'(IPR_SRC_REG[i]) == widx &&
            state.w_strb[IPR_SRC_LSB[i] / 8]) begin
          next_state.prio[i] = state.w_data[IPR_SRC_LSB[i] +: 3];
        end
      end
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (do_read) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = IPR_RESP_OKAY;
      if (ridx < 5'(IPR_NUM_REGS)) begin
        next_state.rdata = reg_word(state.prio, ridx);
      end else if (ridx == 5'h09) begin
        next_state.rdata = '0;
        next_state.rdata[IPR_WIN_VALID_BIT] = win_valid;
        next_state.rdata[IPR_WIN_SRC_LSB +: 5] = win_src;
        next_state.rdata[2:0] = win_level;
      end else begin
        next_state.rdata = '0;
        next_state.rresp = IPR_RESP_SLVERR;
      end
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
  end

  // Whole state registered at once; every field comes up at level 4
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.prio <= {NSRC{IPR_PRIO_RESET}};
    end else begin
      state <= next_state;
    end
  end

  // Handshakes are combinational; one write and one read outstanding
  assign s_axi_awready = !state.aw_held && !state.bvalid;
  assign s_axi_wready = !state.w_held && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign src_level = state.prio;

  ipr_arbiter #(.NSRC(NSRC)) u_arb (
    .clk(clk),
    .rst_n(rst_n),
    .pending(irq_pending),
    .levels(state.prio),
    .win_valid(win_valid),
    .win_src(win_src),
    .win_level(win_level)
  );
  // Winner presented to the core, one cycle behind the pending inputs
  assign irq_valid = win_valid;
  assign irq_src = win_src;
  assign irq_level = win_level;

  chk_reset_level_four: assert property (@(posedge clk)
    $rose(rst_n) |-> src_level == {NSRC{IPR_PRIO_RESET}}) else $error("reset level not 4");
  chk_write_stores_field: assert property (@(posedge clk) disable iff (!rst_n)
    do_write && widx == 5'h00 && state.w_strb[1]
    |=> src_level[2:0] == $past(state.w_data[14:12])) else $error("timer2 field not stored");
  chk_unimpl_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
    do_read && ridx < 5'(IPR_NUM_REGS) |=> s_axi_rdata[31:15] == '0 && s_axi_rdata[11] == 1'b0
    && s_axi_rdata[7] == 1'b0) else $error("unimplemented bits nonzero");
  chk_adc_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    do_read && ridx == 5'h02 |=> s_axi_rdata[15:7] == '0) else $error("adc register upper bits");
  chk_ext1_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    do_read && ridx == 5'h04 |=> s_axi_rdata[15:3] == '0) else $error("ext line1 upper bits");
  chk_capture3_layout: assert property (@(posedge clk) disable iff (!rst_n)
    do_read && ridx == 5'h06 |=> s_axi_rdata[3:0] == '0 && s_axi_rdata[15:7] == '0)
    else $error("capture3 layout");
  chk_pwm_readback: assert property (@(posedge clk) disable iff (!rst_n)
    do_read && ridx == 5'h07 |=> s_axi_rdata[6:4] == src_level[3*16 +: 3])
    else $error("pwm readback");
  chk_fault_calendar: assert property (@(posedge clk) disable iff (!rst_n)
    do_read && ridx == 5'h08 |=> s_axi_rdata[14:12] == src_level[3*17 +: 3]
    && s_axi_rdata[10:8] == src_level[3*18 +: 3]) else $error("fault calendar layout");
  chk_level_seven_wins: assert property (@(posedge clk) disable iff (!rst_n)
    irq_pending[0] && src_level[2:0] == 3'h7 |=> irq_valid && irq_level == 3'h7)
    else $error("level 7 lost");
  chk_write_answers: assert property (@(posedge clk) disable iff (!rst_n)
    do_write |=> s_axi_bvalid) else $error("no write response");
  cov_write: cover property (@(posedge clk) do_write);
  cov_read: cover property (@(posedge clk) do_read);
  cov_winner: cover property (@(posedge clk) irq_valid && irq_level == 3'h7);
endmodule : ipr_regs
`default_nettype wire

// ---- hdl/ipr_pkg.sv ----
// Package of offsets, field layouts and reset values for the priority register bank
package ipr_pkg;
  localparam int IPR_NUM_REGS = 9;
  localparam int IPR_NUM_SRC = 19;
  localparam int IPR_ADDR_W = 6;
  // Byte addresses of the priority registers, one aligned word each
  localparam logic [5:0] IPR_OFF_TIMER2_OC2_IC2 = 6'h00;
  localparam logic [5:0] IPR_OFF_UART_RX_SPI_TIMER3 = 6'h04;
  localparam logic [5:0] IPR_OFF_ADC_UART_TX = 6'h08;
  localparam logic [5:0] IPR_OFF_CHANGE_CMP_I2C = 6'h0C;
  localparam logic [5:0] IPR_OFF_EXT_INT1 = 6'h10;
  localparam logic [5:0] IPR_OFF_EXT_INT2 = 6'h14;
  localparam logic [5:0] IPR_OFF_CAPTURE3 = 6'h18;
  localparam logic [5:0] IPR_OFF_MOTOR_PWM = 6'h1C;
  localparam logic [5:0] IPR_OFF_FAULT_A_CALENDAR = 6'h20;
  // Winner status register: bit 8 valid, bits 7-3 source index, bits 2-0 level
  localparam logic [5:0] IPR_OFF_WINNER = 6'h24;
  localparam int IPR_WIN_VALID_BIT = 8;
  localparam int IPR_WIN_SRC_LSB = 3;
  // Reset level 4: top bit set, two lower bits clear
  localparam logic [2:0] IPR_PRIO_RESET = 3'h4;
  localparam logic [2:0] IPR_PRIO_OFF = 3'h0;
  localparam logic [1:0] IPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPR_RESP_SLVERR = 2'h2;
  // Per source: register index and field low bit
  localparam logic [3:0] IPR_SRC_REG [IPR_NUM_SRC] = '{
    4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3,
    4'h3, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8};
  localparam logic [3:0] IPR_SRC_LSB [IPR_NUM_SRC] = '{
    4'hC, 4'h8, 4'h4, 4'hC, 4'h8, 4'h4, 4'h0, 4'h4, 4'h0, 4'hC,
    4'h8, 4'h4, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4, 4'hC, 4'h8};
  typedef enum logic [1:0] {IPR_RD_IDLE, IPR_RD_WAIT, IPR_RD_DATA} ipr_rd_state_t;
endpackage : ipr_pkg

// ---- hdl/ipr_arbiter.sv ----
// Fixed-order arbiter that picks the pending source with the highest priority
`timescale 1ns/1ps
`default_nettype none
module ipr_arbiter import ipr_pkg::*; #(
  parameter int NSRC = IPR_NUM_SRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NSRC-1:0] pending,
  input wire logic [3*NSRC-1:0] levels,
  output logic win_valid,
  output logic [4:0] win_src,
  output logic [2:0] win_level
);
  typedef struct packed {
    logic valid;
    logic [4:0] src;
    logic [2:0] level;
  } ipr_arb_t;
  ipr_arb_t state;
  ipr_arb_t next_state;

  // Strictly greater keeps the lowest index on a tie
  always_comb begin
    next_state = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (pending[i] && levels[3*i +: 3] != IPR_PRIO_OFF &&
          levels[3*i +: 3] > next_state.level) begin
        next_state.valid = 1'b1;
        next_state.src = 5'(i);
        next_state.level = levels[3*i +: 3];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign win_valid = state.valid;
  assign win_src = state.src;
  assign win_level = state.level;

  chk_disabled_never_wins: assert property (@(posedge clk) disable iff (!rst_n)
    win_valid |-> win_level != IPR_PRIO_OFF) else $error("disabled source won");
  chk_winner_is_max: assert property (@(posedge clk) disable iff (!rst_n)
    (|pending) ##1 win_valid |-> win_level >= $past(levels[2:0]) || !$past(pending[0]))
    else $error("winner below source 0 level");
endmodule : ipr_arbiter
`default_nettype wire

// ---- testbench/ipr_src_model.sv ----
// Model of the peripheral sources that raise pending lines toward the bank
`timescale 1ns/1ps
`default_nettype none
module ipr_src_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [18:0] raise,
  output logic [18:0] pending
);
  // Requests are held as levels one flop behind the command, like a real flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pending <= 19'h0;
    else pending <= raise;
  end
endmodule : ipr_src_model
`default_nettype wire

// ---- testbench/test_interrupt_priority_regs.sv ----
// Self-checking bench for the priority register bank
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_priority_regs import ipr_pkg::*;;
  typedef struct packed {logic [5:0] a; logic [15:0] rv; logic [15:0] wm;} ipr_row_t;
  // Address, reset value, readback after writing all ones
  ipr_row_t rows [9] = '{'{6'h00, 16'h4440, 16'h7770}, '{6'h04, 16'h4444, 16'h7777},
    '{6'h08, 16'h0044, 16'h0077}, '{6'h0C, 16'h4444, 16'h7777}, '{6'h10, 16'h0004, 16'h0007},
    '{6'h14, 16'h0040, 16'h0070}, '{6'h18, 16'h0040, 16'h0070}, '{6'h1C, 16'h0040, 16'h0070},
    '{6'h20, 16'h4400, 16'h7700}};
  logic clk = 1'b0, rst_n = 1'b0;
  logic [5:0] awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_valid;
  logic [1:0] bresp, rresp, r;
  logic [18:0] raise = 19'h0, pending;
  logic [56:0] src_level;
  logic [4:0] irq_src;
  logic [2:0] irq_level;
  int n_errors = 0, check_count = 0, cycles = 0;
  ipr_regs u_ipr_regs (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_pending(pending), .src_level(src_level), .irq_valid(irq_valid), .irq_src(irq_src),
    .irq_level(irq_level));
  ipr_src_model u_ipr_src_model (.clk(clk), .rst_n(rst_n), .raise(raise), .pending(pending));
  initial begin
    forever #25 clk = ~clk;
  end
  // Handshakes are judged mid-cycle, where the combinational readies have settled
  task axi_wr(input logic [5:0] a, input logic [31:0] v);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_ok, r_ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  // Winner word as valid, source, level; irq outputs follow pending a few edges later
  task chk_win(input logic [31:0] e);
    repeat (4) @(posedge clk);
    chk("winner", e, {23'h0, irq_valid, irq_src, irq_level});
  endtask : chk_win
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // Whole run is under two hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      axi_rd(rows[i].a, d, r);
      chk("reset value", {16'h0, rows[i].rv}, d);
      axi_wr(rows[i].a, 32'hFFFFFFFF);
      chk("write resp", {30'h0, IPR_RESP_OKAY}, {30'h0, bresp});
      axi_rd(rows[i].a, d, r);
      chk("field mask", {16'h0, rows[i].wm}, d);
      chk("read resp", {30'h0, IPR_RESP_OKAY}, {30'h0, r});
    end
    $display("test register table done");
    for (int i = 0; i < 9; i++) axi_wr(rows[i].a, 32'h0);
    raise <= 19'h7FFFF;
    chk_win(32'h0);
    axi_wr(6'h00, 32'h1000);
    chk_win(32'h101);
    axi_wr(6'h20, 32'h7700);
    chk_win(32'h18F);
    chk("fault level", 32'h7, {29'h0, src_level[53:51]});
    raise <= 19'h00001;
    chk_win(32'h101);
    $display("test arbitration done");
    axi_rd(6'h28, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", {30'h0, IPR_RESP_SLVERR}, {30'h0, r});
    // Response code stays on the bus after the handshake, so it is read back here
    axi_wr(6'h28, 32'hFFFFFFFF);
    chk("unmapped wresp", {30'h0, IPR_RESP_SLVERR}, {30'h0, bresp});
    @(posedge clk);
    rst_n <= 1'b0;
    raise <= 19'h7FFFF;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(6'h20, d, r);
    chk("reset again", 32'h4400, d);
    chk_win(32'h104);
    $display("test reset and unmapped done");
    wrap_up();
  end
endmodule : test_interrupt_priority_regs
`default_nettype wire
